// file: core/ptp_pkg.sv
package ptp_pkg;

  // command opcodes seen on the serial command decoder
  localparam logic [7:0] OP_SET_PTR3 = 8'hFB;
  localparam logic [7:0] OP_SET_PTR4 = 8'hE3;
  localparam logic [7:0] OP_WRITE_ANY = 8'h71;
  localparam logic [7:0] OP_READ_ANY = 8'h65;
  localparam logic [7:0] OP_LOCK = 8'hA6;
  localparam logic [7:0] OP_PASS_UNLOCK = 8'hEA;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hCE;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hD8;
  localparam logic [7:0] OP_SECR_PROG = 8'h42;
  localparam logic [7:0] OP_SECR_ERASE = 8'h44;
  localparam logic [7:0] OP_SECR_READ = 8'h48;
  localparam logic [7:0] OP_CLR_STATUS = 8'h30;

  // register addresses reached by the generic read/write commands
  localparam logic [31:0] ANY_PTR_ADDR = 32'h0000_0027;
  localparam logic [31:0] ANY_LOCK_ADDR = 32'h0000_0020;

  // field positions inside a pointer write and the lock register
  localparam int PTR_DIR_BIT = 9;
  localparam int PTR_DIS_BIT = 10;
  localparam int PTR_ALL_BIT = 11;
  localparam int PTR_BND_LSB = 12;
  localparam int LOCK_R3RD_BIT = 6;

  // sector geometry: 4KB sectors, 32 MB array
  localparam int SECT_W = 13;
  localparam logic [SECT_W-1:0] HALF_SECTS = 13'h0007;
  localparam logic [SECT_W-1:0] BLOCK_SECTS = 13'h000F;

  // software port offsets and bit positions
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_POINTER = 8'h08;
  localparam int CTRL_ADDR4_BIT = 0;
  localparam int CTRL_SEL_BIT = 2;
  localparam int ST_PERR_BIT = 4;
  localparam int ST_EERR_BIT = 5;

  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // password retry lockout
  localparam int PASS_DELAY_US = 100;
  localparam int CLK_MHZ = 100;
  localparam int PASS_DELAY_CYC = PASS_DELAY_US * CLK_MHZ;
  localparam int LOCKOUT_W = 14;

  // lock management method
  typedef enum logic [1:0] {MODE_LOCKDOWN, MODE_PASSWORD, MODE_PERMANENT} ptp_mode_t;

  // stored pointer
  typedef struct packed {
    logic [19:0] boundary;
    logic allProt;
    logic disable_;
    logic dirUp;
  } ptp_ptr_t;

  // one command from the serial decoder
  typedef struct packed {
    logic [7:0] opcode;
    logic [31:0] addr;
    logic [63:0] data;
  } ptp_cmd_t;

endpackage : ptp_pkg

// file: core/ptp_protect.sv
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/10ps
module ptp_protect #(
  parameter int PASS_LOCKOUT_CYC = ptp_pkg::PASS_DELAY_CYC
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clkEn,
  // software register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // command stream from the serial decoder
  input wire logic cmdValid,
  input wire ptp_pkg::ptp_cmd_t cmdIn,
  // device status and non-volatile images
  input wire logic suspended,
  input wire logic legacyProtHit,
  input wire logic perBlockLockBit,
  input wire ptp_pkg::ptp_ptr_t nvPtrImage,
  input wire logic [6:0] protModeOtp,
  input wire logic [1:0] regionOtpLock,
  input wire logic [63:0] hiddenPassword,
  // results
  output logic cmdGrant,
  output logic cmdDeny,
  output logic [31:0] anyRdData,
  output logic anyRdValid,
  output logic nvPtrWrite,
  output ptp_pkg::ptp_ptr_t nvPtrData,
  output logic busy,
  output logic progErr,
  output logic eraseErr,
  output logic regionLockBit,
  output logic region3ReadEnable
);

  // state
  logic initDone;
  ptp_pkg::ptp_mode_t mode;
  ptp_pkg::ptp_ptr_t ptr;
  logic [31:0] ctrl;
  logic [ptp_pkg::LOCKOUT_W-1:0] lockout;
  logic next_initDone;
  ptp_pkg::ptp_mode_t next_mode;
  ptp_pkg::ptp_ptr_t next_ptr;
  logic [31:0] next_ctrl;
  logic [ptp_pkg::LOCKOUT_W-1:0] next_lockout;
  logic next_cmdGrant;
  logic next_cmdDeny;
  logic [31:0] next_anyRdData;
  logic next_anyRdValid;
  logic next_nvPtrWrite;
  ptp_pkg::ptp_ptr_t next_nvPtrData;
  logic next_busy;
  logic next_progErr;
  logic next_eraseErr;
  logic next_regionLockBit;
  logic next_region3ReadEnable;
  logic [31:0] next_regRdData;

  // sector range test against the pointer window
  function automatic logic ptrCovers(input ptp_pkg::ptp_ptr_t p,
                                     input logic [ptp_pkg::SECT_W-1:0] lo,
                                     input logic [ptp_pkg::SECT_W-1:0] hi);
    logic [19:0] loW;
    logic [19:0] hiW;
    loW = {7'h00, lo};
    hiW = {7'h00, hi};
    if (p.disable_)
      ptrCovers = 1'b0;
    else if (p.allProt)
      ptrCovers = 1'b1;
    else if (p.dirUp)
      ptrCovers = (loW < p.boundary);
    else
      ptrCovers = (hiW > p.boundary);
  endfunction : ptrCovers

  // pointer fields taken from an address or data word
  function automatic ptp_pkg::ptp_ptr_t ptrFromWord(input logic [31:0] w,
                                                    input logic wide);
    ptp_pkg::ptp_ptr_t p;
    p.boundary = wide ? w[31:ptp_pkg::PTR_BND_LSB] : {8'h00, w[23:ptp_pkg::PTR_BND_LSB]};
    p.allProt = w[ptp_pkg::PTR_ALL_BIT];
    p.disable_ = w[ptp_pkg::PTR_DIS_BIT];
    p.dirUp = w[ptp_pkg::PTR_DIR_BIT];
    ptrFromWord = p; // low reserved bits dropped
  endfunction : ptrFromWord

  // pointer as read back, reserved positions as ones
  function automatic logic [31:0] ptrToWord(input ptp_pkg::ptp_ptr_t p);
    ptrToWord = {p.boundary, p.allProt, p.disable_, p.dirUp, 9'h1FF};
  endfunction : ptrToWord

  // working values for the command decode
  logic [ptp_pkg::SECT_W-1:0] sectLo;
  logic [ptp_pkg::SECT_W-1:0] sectHi;
  logic [ptp_pkg::SECT_W-1:0] sectAt;
  logic otherProt;
  logic ptrWriteReq;
  logic ptrWriteOk;
  logic [1:0] secRegion;
  logic secDenied;
  logic isPtrAnyAddr;
  logic errClrP;
  logic errClrE;

  // next-state decode
  always_comb
  begin
    next_initDone = initDone;
    next_mode = mode;
    next_ptr = ptr;
    next_ctrl = ctrl;
    next_lockout = lockout;
    next_cmdGrant = 1'b0;
    next_cmdDeny = 1'b0;
    next_anyRdData = 32'h0000_0000;
    next_anyRdValid = 1'b0;
    next_nvPtrWrite = 1'b0;
    next_nvPtrData = nvPtrData;
    next_busy = busy;
    next_progErr = progErr;
    next_eraseErr = eraseErr;
    next_regionLockBit = regionLockBit;
    next_region3ReadEnable = region3ReadEnable;
    next_regRdData = 32'h0000_0000;
    sectAt = cmdIn.addr[ptp_pkg::PTR_BND_LSB +: ptp_pkg::SECT_W];
    sectLo = sectAt;
    sectHi = sectAt;
    otherProt = ctrl[ptp_pkg::CTRL_SEL_BIT] ? ~perBlockLockBit : legacyProtHit;
    isPtrAnyAddr = (cmdIn.addr == ptp_pkg::ANY_PTR_ADDR);
    ptrWriteReq = 1'b0;
    ptrWriteOk = 1'b0;
    secRegion = cmdIn.addr[9:8];
    secDenied = 1'b0;
    errClrP = 1'b0;
    errClrE = 1'b0;

    // software writes: control bits and write-one-to-clear errors
    if (regWr && regAddr == ptp_pkg::REG_CTRL)
      next_ctrl = regWrData & 32'h0000_0005;
    if (regWr && regAddr == ptp_pkg::REG_STATUS)
    begin
      errClrP = regWrData[ptp_pkg::ST_PERR_BIT];
      errClrE = regWrData[ptp_pkg::ST_EERR_BIT];
    end
    // clears go first so a set by this cycle's command still wins
    if (errClrP)
      next_progErr = 1'b0;
    if (errClrE)
      next_eraseErr = 1'b0;

    // software reads, unmapped offsets read as zero
    if (regRd)
    begin
      unique case (regAddr)
        ptp_pkg::REG_CTRL: next_regRdData = ctrl;
        ptp_pkg::REG_STATUS: next_regRdData = {26'h0000000, eraseErr, progErr, busy,
                                               region3ReadEnable, initDone, regionLockBit};
        ptp_pkg::REG_POINTER: next_regRdData = ptrToWord(ptr);
        default: next_regRdData = 32'h0000_0000;
      endcase
    end

    // password lockout countdown holds busy
    if (lockout != '0)
    begin
      next_lockout = lockout - 1'b1;
      if (lockout == ptp_pkg::LOCKOUT_W'(1))
        next_busy = 1'b0;
    end

    if (!initDone)
    begin
      // first cycle after reset: take the stored pointer and the method
      next_initDone = 1'b1;
      next_ptr = nvPtrImage;
      if (!protModeOtp[0])
      begin
        next_mode = ptp_pkg::MODE_PERMANENT;
        next_regionLockBit = 1'b0;
        next_region3ReadEnable = 1'b1;
      end
      else if (!protModeOtp[2])
      begin
        next_mode = ptp_pkg::MODE_PASSWORD;
        next_regionLockBit = 1'b0;
        next_region3ReadEnable = protModeOtp[6];
      end
      else
      begin
        next_mode = ptp_pkg::MODE_LOCKDOWN;
        next_regionLockBit = 1'b1;
        next_region3ReadEnable = 1'b1;
      end
    end
    else if (cmdValid && !busy)
    begin
      unique case (cmdIn.opcode)
        ptp_pkg::OP_SET_PTR3, ptp_pkg::OP_SET_PTR4:
        begin
          ptrWriteReq = 1'b1;
          ptrWriteOk = regionLockBit && !suspended;
          next_nvPtrData = ptrFromWord(cmdIn.addr, cmdIn.opcode == ptp_pkg::OP_SET_PTR4 ||
                                       ctrl[ptp_pkg::CTRL_ADDR4_BIT]);
        end
        ptp_pkg::OP_WRITE_ANY:
        begin
          if (isPtrAnyAddr)
          begin
            ptrWriteReq = 1'b1;
            ptrWriteOk = regionLockBit;
            next_nvPtrData = ptrFromWord(cmdIn.data[31:0], ctrl[ptp_pkg::CTRL_ADDR4_BIT]);
          end
          else
            next_cmdDeny = 1'b1;
        end
        ptp_pkg::OP_READ_ANY:
        begin
          next_anyRdValid = 1'b1;
          if (isPtrAnyAddr)
            next_anyRdData = ptrToWord(ptr);
          else if (cmdIn.addr == ptp_pkg::ANY_LOCK_ADDR)
            next_anyRdData = {25'h0000000, region3ReadEnable, 5'h00, regionLockBit};
        end
        ptp_pkg::OP_LOCK:
        begin
          next_regionLockBit = 1'b0;
          next_cmdGrant = 1'b1;
        end
        ptp_pkg::OP_PASS_UNLOCK:
        begin
          if (mode != ptp_pkg::MODE_PASSWORD)
            next_cmdDeny = 1'b1;
          else if (cmdIn.data == hiddenPassword)
          begin
            next_regionLockBit = 1'b1;
            next_cmdGrant = 1'b1;
          end
          else
          begin
            next_progErr = 1'b1;
            next_busy = 1'b1;
            next_lockout = ptp_pkg::LOCKOUT_W'(PASS_LOCKOUT_CYC);
            next_cmdDeny = 1'b1;
          end
        end
        ptp_pkg::OP_CHIP_ERASE:
        begin
          if (!ptr.disable_)
          begin
            next_eraseErr = 1'b1;
            next_cmdDeny = 1'b1;
          end
          else if (otherProt)
            next_cmdDeny = 1'b1;
          else
            next_cmdGrant = 1'b1;
        end
        ptp_pkg::OP_PROG, ptp_pkg::OP_ERASE_4K, ptp_pkg::OP_ERASE_32K,
        ptp_pkg::OP_ERASE_64K:
        begin
          if (cmdIn.opcode == ptp_pkg::OP_ERASE_32K)
          begin
            sectLo = sectAt & ~ptp_pkg::HALF_SECTS;
            sectHi = sectAt | ptp_pkg::HALF_SECTS;
          end
          else if (cmdIn.opcode == ptp_pkg::OP_ERASE_64K)
          begin
            sectLo = sectAt & ~ptp_pkg::BLOCK_SECTS;
            sectHi = sectAt | ptp_pkg::BLOCK_SECTS;
          end
          if (ptrCovers(ptr, sectLo, sectHi) || otherProt)
          begin
            next_cmdDeny = 1'b1;
            if (cmdIn.opcode == ptp_pkg::OP_PROG)
              next_progErr = 1'b1;
            else
              next_eraseErr = 1'b1;
          end
          else
            next_cmdGrant = 1'b1;
        end
        ptp_pkg::OP_SECR_PROG, ptp_pkg::OP_SECR_ERASE:
        begin
          if (secRegion[1])
          begin
            secDenied = !regionLockBit;
            if (secRegion[0] ? regionOtpLock[1] : regionOtpLock[0])
              secDenied = 1'b1;
          end
          if (secDenied)
          begin
            next_cmdDeny = 1'b1;
            if (cmdIn.opcode == ptp_pkg::OP_SECR_PROG)
              next_progErr = 1'b1;
            else
              next_eraseErr = 1'b1;
          end
          else
            next_cmdGrant = 1'b1;
        end
        ptp_pkg::OP_SECR_READ:
        begin
          if (secRegion == 2'h3 && !region3ReadEnable)
            next_cmdDeny = 1'b1;
          else
            next_cmdGrant = 1'b1;
        end
        ptp_pkg::OP_CLR_STATUS:
        begin
          errClrP = 1'b1;
          errClrE = 1'b1;
          next_progErr = 1'b0;
          next_eraseErr = 1'b0;
        end
        default:
        begin
          // opcodes outside this block pass untouched
        end
      endcase

      // pointer update, skipped entirely when refused
      if (ptrWriteReq)
      begin
        if (ptrWriteOk)
        begin
          next_ptr = next_nvPtrData;
          next_nvPtrWrite = 1'b1;
          next_cmdGrant = 1'b1;
        end
        else
        begin
          next_nvPtrData = nvPtrData;
          next_cmdDeny = 1'b1;
          if (cmdIn.opcode == ptp_pkg::OP_WRITE_ANY)
            next_progErr = 1'b1;
        end
      end
    end

    // permanent method pins the lock state
    if (initDone && mode == ptp_pkg::MODE_PERMANENT)
    begin
      next_regionLockBit = 1'b0;
      next_region3ReadEnable = 1'b1;
    end
  end

  // state registers, frozen while the clock enable is low
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      initDone <= 1'b0;
      mode <= ptp_pkg::MODE_LOCKDOWN;
      ptr <= '0;
      ctrl <= ptp_pkg::CTRL_RESET;
      lockout <= '0;
      cmdGrant <= 1'b0;
      cmdDeny <= 1'b0;
      anyRdData <= 32'h0000_0000;
      anyRdValid <= 1'b0;
      nvPtrWrite <= 1'b0;
      nvPtrData <= '0;
      busy <= 1'b0;
      progErr <= 1'b0;
      eraseErr <= 1'b0;
      regionLockBit <= 1'b0;
      region3ReadEnable <= 1'b0;
      regRdData <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      initDone <= next_initDone;
      mode <= next_mode;
      ptr <= next_ptr;
      ctrl <= next_ctrl;
      lockout <= next_lockout;
      cmdGrant <= next_cmdGrant;
      cmdDeny <= next_cmdDeny;
      anyRdData <= next_anyRdData;
      anyRdValid <= next_anyRdValid;
      nvPtrWrite <= next_nvPtrWrite;
      nvPtrData <= next_nvPtrData;
      busy <= next_busy;
      progErr <= next_progErr;
      eraseErr <= next_eraseErr;
      regionLockBit <= next_regionLockBit;
      region3ReadEnable <= next_region3ReadEnable;
      regRdData <= next_regRdData;
    end
  end

endmodule : ptp_protect

// file: test/ptp_host.sv
`timescale 1ns/10ps
module ptp_host (
  // clock
  input wire logic mclk,
  // command stream towards the block
  output logic cmdValid,
  output ptp_pkg::ptp_cmd_t cmdIn
);
  // idle lines start low
  initial
  begin
    cmdValid = 1'b0;
    cmdIn = '0;
  end

  // one command pulse, then fields flip so a stale value never passes
  task automatic send(input logic [7:0] op, input logic [31:0] a, input logic [63:0] d);
    cmdValid <= 1'b1;
    cmdIn <= '{op, a, d};
    @(posedge mclk);
    cmdValid <= 1'b0;
    cmdIn <= ~cmdIn;
    @(posedge mclk);
  endtask : send
endmodule : ptp_host

// file: test/ptp_protect_assertions.sv
`timescale 1ns/10ps
module ptp_protect_assertions #(
  parameter int PASS_LOCKOUT_CYC = 5
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clkEn,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  // command side
  input wire logic cmdValid,
  input wire ptp_pkg::ptp_cmd_t cmdIn,
  input wire logic suspended,
  input wire logic [63:0] hiddenPassword,
  // results
  input wire logic cmdGrant,
  input wire logic cmdDeny,
  input wire logic anyRdValid,
  input wire logic nvPtrWrite,
  input wire logic busy,
  input wire logic eraseErr,
  input wire logic regionLockBit
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic [1:0] upCnt;
  int busyCnt;
  logic taken;

  // a command counts once the init edge has passed and no lockout runs
  assign taken = cmdValid && clkEn && !busy && upCnt != 2'h0;

  // edges since reset release and length of the current busy stretch
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      upCnt <= 2'h0;
      busyCnt <= 0;
    end
    else
    begin
      upCnt <= (upCnt == 2'h2) ? upCnt : upCnt + 2'h1;
      busyCnt <= busy ? busyCnt + 1 : 0;
    end
  end

  sequence sSetPtr;
    taken && (cmdIn.opcode == ptp_pkg::OP_SET_PTR3 || cmdIn.opcode == ptp_pkg::OP_SET_PTR4);
  endsequence
  sequence sBadPwd;
    taken && cmdIn.opcode == ptp_pkg::OP_PASS_UNLOCK && cmdIn.data != hiddenPassword;
  endsequence

  a_one_answer: assert property (!(cmdGrant && cmdDeny))
    else $error("grant and deny together");
  a_setptr_blocked: assert property (sSetPtr ##0 (!regionLockBit || suspended)
    |=> cmdDeny && !nvPtrWrite) else $error("pointer set while locked or suspended");
  a_pwd_mismatch: assert property (sBadPwd |=> cmdDeny && !$rose(regionLockBit))
    else $error("bad password not refused");
  a_lock_rise: assert property ($rose(regionLockBit) && upCnt == 2'h2 |->
    $past(cmdValid && cmdIn.opcode == ptp_pkg::OP_PASS_UNLOCK && cmdIn.data == hiddenPassword))
    else $error("lock bit set without matching password");
  a_lock_cmd: assert property (taken && cmdIn.opcode == ptp_pkg::OP_LOCK |=> !regionLockBit)
    else $error("lock command left lock bit set");
  a_busy_span: assert property (busyCnt <= PASS_LOCKOUT_CYC)
    else $error("lockout too long");
  a_busy_quiet: assert property (busy && cmdValid |=> !cmdGrant && !cmdDeny && !anyRdValid)
    else $error("command answered during lockout");
  a_ptr_write: assert property (nvPtrWrite |-> cmdGrant && $past(taken))
    else $error("pointer stored without granted command");
  a_rd_slot: assert property (!$past(regRd) |-> regRdData == 32'h0)
    else $error("read data outside its slot");
  a_anyrd_src: assert property (anyRdValid |-> $past(cmdValid && cmdIn.opcode == 8'h65))
    else $error("generic read answer without request");
  a_eerr_clear: assert property ($fell(eraseErr) |->
    $past(regWr && regAddr == ptp_pkg::REG_STATUS && regWrData[ptp_pkg::ST_EERR_BIT]))
    else $error("erase error dropped without clear");
endmodule : ptp_protect_assertions

bind ptp_protect ptp_protect_assertions #(.PASS_LOCKOUT_CYC(PASS_LOCKOUT_CYC)) u_chk (
  .mclk, .rst_b, .clkEn, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .cmdValid, .cmdIn,
  .suspended, .hiddenPassword, .cmdGrant, .cmdDeny, .anyRdValid, .nvPtrWrite, .busy,
  .eraseErr, .regionLockBit);

// file: test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic suspended = 1'b0;
  logic legacyProtHit = 1'b0;
  logic perBlockLockBit = 1'b1;
  ptp_pkg::ptp_ptr_t nvPtrImage = 23'h2;
  logic [6:0] protModeOtp = 7'h7F;
  logic [1:0] regionOtpLock = 2'h0;
  logic [63:0] hiddenPassword = 64'h0;
  logic [31:0] regRdData, anyRdData;
  logic cmdValid, cmdGrant, cmdDeny, anyRdValid, nvPtrWrite, busy, progErr, eraseErr;
  logic regionLockBit, region3ReadEnable;
  logic rdPend = 1'b0;
  ptp_pkg::ptp_cmd_t cmdIn;
  ptp_pkg::ptp_ptr_t nvPtrData;
  int fails = 0;
  int numChecks = 0;
  int i, s;
  logic [1:0] qk[$];
  logic [31:0] qv[$];
  logic [11:0] bnd, sec, lo;
  logic [2:0] fl;
  logic [7:0] op;
  logic sel, p;

  always #5 mclk = ~mclk;

  ptp_protect #(.PASS_LOCKOUT_CYC(5)) DUT (.mclk, .rst_b, .clkEn, .regAddr, .regWrData,
    .regWr, .regRd, .regRdData, .cmdValid, .cmdIn, .suspended, .legacyProtHit,
    .perBlockLockBit, .nvPtrImage, .protModeOtp, .regionOtpLock, .hiddenPassword,
    .cmdGrant, .cmdDeny, .anyRdData, .anyRdValid, .nvPtrWrite, .nvPtrData, .busy,
    .progErr, .eraseErr, .regionLockBit, .region3ReadEnable);
  ptp_host host (.mclk, .cmdValid, .cmdIn);

  // non-volatile pointer storage outside the block
  always @(posedge mclk)
  begin
    rdPend <= regRd;
    if (nvPtrWrite)
      nvPtrImage <= nvPtrData;
  end

  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    numChecks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic note(input logic [1:0] k, input logic [31:0] v);
    qk.push_back(k);
    qv.push_back(v);
  endtask : note

  // each result consumes the oldest note
  task automatic take(input logic [1:0] k, input logic [31:0] g);
    if (qk.size() == 0)
      chk("stray result", 36'h0, {2'h1, k, g});
    else
      chk("result", {2'h0, qk.pop_front(), qv.pop_front()}, {2'h0, k, g});
  endtask : take

  always @(negedge mclk)
  begin
    if (cmdGrant || cmdDeny)
      take(2'h0, {30'h0, cmdDeny, cmdGrant});
    if (anyRdValid)
      take(2'h1, anyRdData);
    if (rdPend)
      take(2'h2, regRdData);
  end

  task automatic cmd(input logic [7:0] o, input logic [31:0] a, input logic [63:0] d,
                     input logic [1:0] r);
    if (r != 2'h0)
      note(2'h0, {30'h0, r});
    host.send(o, a, d);
    #1;
  endtask : cmd

  task automatic regW(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    @(posedge mclk);
    #1;
  endtask : regW

  task automatic regR(input logic [7:0] a, input logic [31:0] e);
    note(2'h2, e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(posedge mclk);
    #1;
  endtask : regR

  task automatic rst(input logic [6:0] m);
    rst_b <= 1'b0;
    protModeOtp <= m;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
  endtask : rst

  task automatic finalReport;
    if (qk.size() != 0)
      fails++;
    $display("checks %0d fails %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finalReport

  // hang guard
  initial
  begin
    repeat (20000) @(posedge mclk);
    fails++;
    finalReport;
  end

  // main sequence
  initial
  begin
    void'($urandom(32'h61b0));
    hiddenPassword <= {$urandom(), $urandom()};
    rst(7'h7F);
    chk("regionLockBit", 1, regionLockBit);
    // a command seen while the clock enable is low must leave no trace
    clkEn <= 1'b0;
    cmd(ptp_pkg::OP_LOCK, 32'h0, 64'h0, 2'h0);
    clkEn <= 1'b1;
    chk("regionLockBit", 1, regionLockBit);
    regR(8'h0C, 32'h0);
    regW(ptp_pkg::REG_CTRL, 32'hFFFF_FFFF);
    regR(ptp_pkg::REG_CTRL, 32'h5);
    regionOtpLock <= 2'h1;
    cmd(ptp_pkg::OP_SECR_PROG, 32'h200, 64'h0, 2'h2);
    cmd(ptp_pkg::OP_SECR_PROG, 32'h300, 64'h0, 2'h1);
    regionOtpLock <= 2'h0;
    for (i = 0; i < 40; i++)
    begin
      bnd = 12'($urandom());
      sec = 12'($urandom());
      fl = 3'($urandom());
      sel = 1'($urandom());
      op = $urandom_range(1) ? ptp_pkg::OP_ERASE_64K : ptp_pkg::OP_ERASE_4K;
      legacyProtHit <= 1'($urandom());
      perBlockLockBit <= 1'($urandom());
      regW(ptp_pkg::REG_CTRL, {29'h0, sel, 2'h0});
      cmd(ptp_pkg::OP_SET_PTR3, {8'h0, bnd, fl, 9'h0}, 64'h0, 2'h1);
      lo = (op == ptp_pkg::OP_ERASE_64K) ? {sec[11:4], 4'h0} : sec;
      p = sel ? !perBlockLockBit : legacyProtHit;
      for (s = lo; s <= ((op == ptp_pkg::OP_ERASE_64K) ? lo + 15 : lo); s++)
        p |= !fl[1] && (fl[2] || (fl[0] ? s < bnd : s > bnd));
      cmd(op, {8'h0, sec, 12'h0}, 64'h0, p ? 2'h2 : 2'h1);
    end
    legacyProtHit <= 1'b0;
    regW(ptp_pkg::REG_CTRL, 32'h1);
    cmd(ptp_pkg::OP_SET_PTR4, 32'h0100_3000, 64'h0, 2'h1);
    chk("nvPtrData", 23'h8018, nvPtrData);
    regW(ptp_pkg::REG_CTRL, 32'h0);
    cmd(ptp_pkg::OP_SET_PTR3, 32'h0000_5055, 64'h0, 2'h1);
    note(2'h1, 32'h0000_51FF);
    cmd(ptp_pkg::OP_READ_ANY, ptp_pkg::ANY_PTR_ADDR, 64'h0, 2'h0);
    regR(ptp_pkg::REG_POINTER, 32'h0000_51FF);
    cmd(ptp_pkg::OP_ERASE_32K, 32'h0, 64'h0, 2'h2);
    cmd(ptp_pkg::OP_ERASE_4K, 32'h5000, 64'h0, 2'h1);
    cmd(ptp_pkg::OP_CHIP_ERASE, 32'h0, 64'h0, 2'h2);
    chk("eraseErr", 1, eraseErr);
    regW(ptp_pkg::REG_STATUS, 32'h30);
    chk("eraseErr", 0, eraseErr);
    cmd(ptp_pkg::OP_WRITE_ANY, ptp_pkg::ANY_PTR_ADDR, 64'hC00, 2'h1);
    chk("nvPtrData", 23'h6, nvPtrData);
    cmd(ptp_pkg::OP_CHIP_ERASE, 32'h0, 64'h0, 2'h1);
    suspended <= 1'b1;
    cmd(ptp_pkg::OP_SET_PTR3, 32'h5000, 64'h0, 2'h2);
    suspended <= 1'b0;
    cmd(ptp_pkg::OP_LOCK, 32'h0, 64'h0, 2'h1);
    chk("regionLockBit", 0, regionLockBit);
    cmd(ptp_pkg::OP_SET_PTR3, 32'h5000, 64'h0, 2'h2);
    cmd(ptp_pkg::OP_WRITE_ANY, ptp_pkg::ANY_PTR_ADDR, 64'h0, 2'h2);
    chk("progErr", 1, progErr);
    cmd(ptp_pkg::OP_PASS_UNLOCK, 32'h0, hiddenPassword, 2'h2);
    rst(7'h7F);
    chk("regionLockBit", 1, regionLockBit);
    regR(ptp_pkg::REG_POINTER, 32'h0000_0DFF);
    rst(7'h3B);
    chk("regionLockBit", 0, regionLockBit);
    chk("region3ReadEnable", 0, region3ReadEnable);
    cmd(ptp_pkg::OP_SECR_PROG, 32'h300, 64'h0, 2'h2);
    cmd(ptp_pkg::OP_PASS_UNLOCK, 32'h0, ~hiddenPassword, 2'h2);
    chk("progErr", 1, progErr);
    chk("busy", 1, busy);
    cmd(ptp_pkg::OP_LOCK, 32'h0, 64'h0, 2'h0);
    repeat (2) @(posedge mclk);
    #1;
    chk("busy", 0, busy);
    cmd(ptp_pkg::OP_PASS_UNLOCK, 32'h0, hiddenPassword, 2'h1);
    chk("regionLockBit", 1, regionLockBit);
    cmd(ptp_pkg::OP_SET_PTR3, 32'h5000, 64'h0, 2'h1);
    cmd(ptp_pkg::OP_LOCK, 32'h0, 64'h0, 2'h1);
    chk("regionLockBit", 0, regionLockBit);
    rst(7'h7E);
    chk("region3ReadEnable", 1, region3ReadEnable);
    cmd(ptp_pkg::OP_PASS_UNLOCK, 32'h0, hiddenPassword, 2'h2);
    chk("regionLockBit", 0, regionLockBit);
    note(2'h1, 32'h40);
    cmd(ptp_pkg::OP_READ_ANY, ptp_pkg::ANY_LOCK_ADDR, 64'h0, 2'h0);
    finalReport;
  end
endmodule : tb_top
